// *** tpg_port.sv ***
// Two-pin GPIO port with data latch, direction and pull-up registers.
// Assumes a classic Wishbone master and synchronous pad inputs.
// How it works
// (R01) Direction bit one makes pin output
// (R02) Output pin drives its data latch bit
// (R03) Data writes store latch, reach output pins
// (R04) Output pin read returns latch value
// (R05) Direction bit zero makes pin input
// (R06) Input pin latch write does not drive
// (R07) Input pin ordinary read returns pin level
// (R08) Read-modify-write read always returns latch
// (R09) Peripheral enable hands pin to peripheral
// (R10) Peripheral-driven pin reads back pin level
// (R11) Software disables peripheral before using GPIO
// (R12) Reset clears all direction bits
// (R13) Standby with pin-state bit forces high-Z
// (R14) Forced standby blocks input, reads low
// (R15) Standby without bit keeps pins unchanged
// (R16) Pull-up bit one connects pull-up
// (R17) Low driven output disconnects pull-up
// (R18) Pins map to bits one and two
// (R19) Unimplemented bits read zero, writes ignored
`timescale 1ns/1ps
`default_nettype none

module tpg_port
    import tpg_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    // Shared peripheral outputs
    input  wire logic [7:0]  periph_oe_i,
    input  wire logic [7:0]  periph_out_i,
    // Pads
    input  wire logic [7:0]  pad_in_i,
    output logic      [7:0]  pad_out_o,
    output logic      [7:0]  pad_oe_o,
    output logic      [7:0]  pad_pullup_o,
    // Internal input path to peripherals
    output logic      [7:0]  pin_level_o
);

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] data_q;
    logic [7:0] dir_q;
    logic [7:0] pullup_q;
    logic [7:0] standby_q;
    logic       ack_q;
    logic       err_q;
    logic [31:0] rdata_q;
    tpg_pad_t   pad_q;
    tpg_pad_t   pad_d;
    logic [7:0] level_q;
    logic [7:0] level_d;
    logic       forced_hiz;
    logic       req;
    logic       wr;
    logic       hit;
    logic [7:0] rd_byte;

    // Request decode; ack drops the cycle after it was given
    assign req = wb_cyc_i & wb_stb_i & ~ack_q & ~err_q;
    assign wr  = req & wb_we_i & wb_sel_i[0];
    assign hit = (wb_adr_i == TPG_OFS_DATA) | (wb_adr_i == TPG_OFS_DIR) |
                 (wb_adr_i == TPG_OFS_PULLUP) | (wb_adr_i == TPG_OFS_STANDBY) |
                 (wb_adr_i == TPG_OFS_RMWRD);

    // Standby override active
    assign forced_hiz = standby_q[TPG_SB_PIN_STATE_BIT] &
                        (standby_q[TPG_SB_STOP_BIT] | standby_q[TPG_SB_WATCH_BIT]); // see (R13)

    ////////////////////////////////////////////////////////////////////////
    // Data latch
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            data_q <= TPG_RST_DATA;
        end else if (wr && wb_adr_i == TPG_OFS_DATA) begin
            data_q <= wb_dat_i[7:0] & TPG_PIN_MASK; // see (R03) see (R06) see (R19)
        end
    end

    // Direction register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            dir_q <= TPG_RST_DIR; // see (R12)
        end else if (wr && wb_adr_i == TPG_OFS_DIR) begin
            dir_q <= wb_dat_i[7:0] & TPG_PIN_MASK; // see (R18) see (R19)
        end
    end

    // Pull-up register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pullup_q <= TPG_RST_PULLUP;
        end else if (wr && wb_adr_i == TPG_OFS_PULLUP) begin
            pullup_q <= wb_dat_i[7:0] & TPG_PIN_MASK; // see (R19)
        end
    end

    // Standby control: pin-state, stop and watch bits
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            standby_q <= TPG_RST_STANDBY;
        end else if (wr && wb_adr_i == TPG_OFS_STANDBY) begin
            standby_q <= {5'h00, wb_dat_i[2:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pad drive computation
    always_comb begin
        pad_d = '0;
        level_d = '0;
        for (int i = 0; i < 8; i++) begin
            if (TPG_PIN_MASK[i]) begin
                if (forced_hiz) begin
                    pad_d.drive_enable[i] = 1'b0;  // see (R13)
                    pad_d.drive_value[i]  = 1'b0;
                    level_d[i]            = 1'b0;  // see (R14)
                end else if (periph_oe_i[i]) begin
                    pad_d.drive_enable[i] = 1'b1;  // see (R09) see (R11)
                    pad_d.drive_value[i]  = periph_out_i[i];
                    level_d[i]            = pad_in_i[i];
                end else begin
                    pad_d.drive_enable[i] = dir_q[i];  // see (R01) see (R05) see (R15)
                    pad_d.drive_value[i]  = data_q[i]; // see (R02)
                    level_d[i]            = pad_in_i[i];
                end
                // Pull-up off while pin drives low
                pad_d.pullup_on[i] = pullup_q[i] &
                    ~(pad_d.drive_enable[i] & ~pad_d.drive_value[i]); // see (R16) see (R17)
            end
        end
    end

    // Registered pad outputs
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pad_q   <= '0;
            level_q <= '0;
        end else begin
            pad_q   <= pad_d;
            level_q <= level_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux
    always_comb begin
        rd_byte = 8'h00;
        unique case (wb_adr_i)
            TPG_OFS_DATA: begin
                for (int i = 0; i < 8; i++) begin
                    // Output GPIO reads latch, else pin level
                    if (dir_q[i] && !periph_oe_i[i] && !forced_hiz) begin
                        rd_byte[i] = data_q[i];  // see (R04)
                    end else begin
                        rd_byte[i] = level_d[i]; // see (R07) see (R10) see (R14)
                    end
                end
                rd_byte = rd_byte & TPG_PIN_MASK; // see (R19)
            end
            TPG_OFS_RMWRD:   rd_byte = data_q;    // see (R08)
            TPG_OFS_DIR:     rd_byte = dir_q;
            TPG_OFS_PULLUP:  rd_byte = pullup_q;
            TPG_OFS_STANDBY: rd_byte = standby_q;
            default:         rd_byte = 8'h00;
        endcase
    end

    // Bus answer one cycle after request
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ack_q   <= 1'b0;
            err_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q   <= req & hit;
            err_q   <= req & ~hit;
            rdata_q <= (req && !wb_we_i && hit) ? {24'h000000, rd_byte} : 32'h0000_0000;
        end
    end

    // Outputs
    assign wb_ack_o     = ack_q;
    assign wb_err_o     = err_q;
    assign wb_dat_o     = rdata_q;
    assign pad_out_o    = pad_q.drive_value;
    assign pad_oe_o     = pad_q.drive_enable;
    assign pad_pullup_o = pad_q.pullup_on;
    assign pin_level_o  = level_q;

endmodule : tpg_port

`default_nettype wire

// *** tpg_pkg.sv ***
// Package for the two-pin GPIO port block.
// Assumes a 32-bit classic Wishbone register bus and a 250 MHz machine clock.
package tpg_pkg;

    // Register byte offsets
    localparam logic [7:0] TPG_OFS_DATA    = 8'h00;
    localparam logic [7:0] TPG_OFS_DIR     = 8'h04;
    localparam logic [7:0] TPG_OFS_PULLUP  = 8'h08;
    localparam logic [7:0] TPG_OFS_STANDBY = 8'h0C;
    localparam logic [7:0] TPG_OFS_RMWRD   = 8'h10;

    // Implemented bit positions and masks
    localparam int         TPG_PIN_ONE_BIT = 1;
    localparam int         TPG_PIN_TWO_BIT = 2;
    localparam logic [7:0] TPG_PIN_MASK    = 8'h06;

    // Standby control field positions
    localparam int TPG_SB_PIN_STATE_BIT = 0;
    localparam int TPG_SB_STOP_BIT      = 1;
    localparam int TPG_SB_WATCH_BIT     = 2;

    // Reset values
    localparam logic [7:0] TPG_RST_DATA    = 8'h00;
    localparam logic [7:0] TPG_RST_DIR     = 8'h00;
    localparam logic [7:0] TPG_RST_PULLUP  = 8'h00;
    localparam logic [7:0] TPG_RST_STANDBY = 8'h00;

    // Per-pin drive bundle towards the pad
    typedef struct packed {
        logic [7:0] drive_value;
        logic [7:0] drive_enable;
        logic [7:0] pullup_on;
    } tpg_pad_t;

endpackage : tpg_pkg

// *** tpg_port_asserts.sv ***
// Checker for the two-pin port: bus answers and pad relations.
// Sees only the port block's pins; bound into every instance.
`timescale 1ns/1ps
`default_nettype none
module tpg_port_asserts
    import tpg_pkg::*;
(
    // Clock, reset, bus
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    // Peripheral and pads
    input wire logic [7:0]  periph_oe_i,
    input wire logic [7:0]  periph_out_i,
    input wire logic [7:0]  pad_in_i,
    input wire logic [7:0]  pad_out_o,
    input wire logic [7:0]  pad_oe_o,
    input wire logic [7:0]  pad_pullup_o,
    input wire logic [7:0]  pin_level_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Bus handshake
    a_ack_resp: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o)
        else $error("request not answered");
    a_ack_pulse: assert property (wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o) else $error("answer too long");
    a_ack_excl: assert property (!(wb_ack_o && wb_err_o)) else $error("ack and err together");
    a_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
    // Pad relations
    a_unimpl_zero: assert property (((pad_oe_o | pad_out_o | pad_pullup_o | pin_level_o) & ~TPG_PIN_MASK) == 8'h0
        && (wb_dat_o & 32'hFFFF_FFF8) == 32'h0) else $error("unimplemented bit set");
    a_pullup_low: assert property ((pad_pullup_o & pad_oe_o & ~pad_out_o) == 8'h0)
        else $error("pull-up on low output");
    a_periph_drive: assert property (periph_oe_i[1] |=> !pad_oe_o[1] || pad_out_o[1] == $past(periph_out_i[1]))
        else $error("peripheral value not driven");
    a_level_src: assert property (pin_level_o[1] |-> $past(pad_in_i[1]))
        else $error("input level without pad high");
    a_reset_clear: assert property (disable iff (1'b0) !rst_n_i |=> pad_oe_o == 8'h0)
        else $error("pins driven after reset");
endmodule : tpg_port_asserts
bind tpg_port tpg_port_asserts u_chk (.*);
`default_nettype wire

// *** tpg_pad_model.sv ***
// Model of the board around the two pins: drivers, pull-up, floating.
// Assumes the port drives with high output enable.
`timescale 1ns/1ps
`default_nettype none
module tpg_pad_model (
    // Port side and outside drivers
    input  wire logic       clk_i,
    input  wire logic [7:0] oe_i,
    input  wire logic [7:0] out_i,
    input  wire logic [7:0] pu_i,
    input  wire logic [7:0] ext_en_i,
    input  wire logic [7:0] ext_val_i,
    output logic      [7:0] pad_o
);
    logic [7:0] last_q = 8'h00;
    // Remember the last driven level only; a floating pin holds its inverse
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < 8; i++) begin
            if (oe_i[i] || ext_en_i[i]) begin
                last_q[i] <= pad_o[i];
            end
        end
    end
    // Port drive wins, then outside driver, then pull-up
    assign pad_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_val_i) | (~oe_i & ~ext_en_i & (pu_i | ~last_q));
endmodule : tpg_pad_model
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the two-pin port over classic Wishbone.
// Assumes the pad model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import tpg_pkg::*;
;
    logic        clk_i = 1'h0, rst_n_i = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0, ack, err, err_seen;
    logic [7:0]  adr = 8'h00, poe = 8'h00, pout = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
    logic [7:0]  pad_in, pad_out, pad_oe, pu, lvl;
    logic [31:0] wdat = 32'h0, rdat, got;
    int          n_errors = 0, comparisons = 0;
    // Clock
    initial forever #2 clk_i = ~clk_i;
    tpg_port dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .periph_oe_i(poe),
        .periph_out_i(pout), .pad_in_i(pad_in), .pad_out_o(pad_out), .pad_oe_o(pad_oe), .pad_pullup_o(pu),
        .pin_level_o(lvl));
    tpg_pad_model u_pad (.clk_i(clk_i), .oe_i(pad_oe), .out_i(pad_out), .pu_i(pu), .ext_en_i(ext_en),
        .ext_val_i(ext_val), .pad_o(pad_in));
    task automatic test_done;
        if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %0t %h %h", $time, g, e);
        end
    endtask : chk
    // One bus cycle, held until ack or err
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat} <= {1'h1, 1'h1, w, a, d};
        for (i = 0; i < 20 && !(ack || err); i++) @(posedge clk_i);
        if (i == 20) begin
            n_errors++;
            test_done();
        end
        got = rdat;
        err_seen = err;
        {cyc, stb} <= 2'h0;
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [7:0] d); wb(1'h1, a, {24'h0, d}); endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e); wb(1'h0, a, 32'h0); chk(got, {24'h0, e}); endtask : rd
    task automatic settle; repeat (2) @(posedge clk_i); endtask : settle
    task automatic pads(input logic [7:0] g, input logic [7:0] e); chk({24'h0, g}, {24'h0, e}); endtask : pads
    // Scenarios
    task automatic s_rst;
        rst_n_i <= 1'h0;
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'h1;
        pads(pad_oe, 8'h00);
        rd(TPG_OFS_DIR, 8'h00);
    endtask : s_rst
    task automatic s_out;
        wr(TPG_OFS_DIR, 8'h06);
        wr(TPG_OFS_PULLUP, 8'h06);
        wr(TPG_OFS_DATA, 8'h04);
        settle();
        pads(pad_oe, 8'h06);
        pads(pad_out, 8'h04);
        pads(pu, 8'h04);
        rd(TPG_OFS_DATA, 8'h04);
        wr(TPG_OFS_DATA, 8'hFF);
        rd(TPG_OFS_DATA, 8'h06);
    endtask : s_out
    task automatic s_in;
        wr(TPG_OFS_DIR, 8'h00);
        wr(TPG_OFS_DATA, 8'h02);
        {ext_en, ext_val} <= 16'hFF04;
        settle();
        pads(pad_oe, 8'h00);
        rd(TPG_OFS_DATA, 8'h04);
        rd(TPG_OFS_RMWRD, 8'h02);
        ext_en <= 8'h00;
    endtask : s_in
    task automatic s_per;
        wr(TPG_OFS_DIR, 8'h06);
        wr(TPG_OFS_DATA, 8'h00);
        {poe, pout} <= 16'h0202;
        settle();
        pads(pad_out, 8'h02);
        rd(TPG_OFS_DATA, 8'h02);
        rd(TPG_OFS_RMWRD, 8'h00);
        poe <= 8'h00;
        settle();
        pads(pad_out, 8'h00);
    endtask : s_per
    task automatic s_sb;
        wr(TPG_OFS_DATA, 8'h06);
        wr(TPG_OFS_STANDBY, 8'h02);
        settle();
        pads(pad_oe & pad_out, 8'h06);
        wr(TPG_OFS_STANDBY, 8'h03);
        {ext_en, ext_val} <= 16'hFF06;
        settle();
        pads(pad_oe, 8'h00);
        pads(lvl, 8'h00);
        rd(TPG_OFS_DATA, 8'h00);
        wr(TPG_OFS_STANDBY, 8'h05);
        settle();
        pads(pad_oe, 8'h00);
        ext_en <= 8'h00;
        wr(TPG_OFS_STANDBY, 8'h00);
        wb(1'h1, 8'h20, 32'h0);
        chk({31'h0, err_seen}, 32'h1);
    endtask : s_sb
    initial begin
        s_rst();
        s_out();
        s_in();
        s_per();
        s_sb();
        s_rst();
        test_done();
    end
endmodule : tb_top
`default_nettype wire
